// [gszio_top.sv]
// Gateway status, setpoint, analog scaling and zone I/O with Avalon-MM registers
`timescale 1ns/1ns
// Notes on behaviour
// RULE1 - Status 15-17 show selected mode code
// RULE2 - Shot mode: status 18-24 show shot number
// RULE3 - Standby: status 22 shows valve lock
// RULE4 - Standby: status 23 shows valve open
// RULE5 - Standby: status 24 shows pump parked
// RULE6 - Four analog in/out; only input 1 used
// RULE7 - Input 1 linear; full scale per mode
// RULE8 - Controller settles input, then strobes input 16
// RULE9 - Controller checks status 4 after strobe
// RULE10 - Pressure outputs span MWP plus 500 psi
// RULE11 - Bar/MPa margins 34.5 and 3.45
// RULE12 - Output 3 blue pressure or combined flow
// RULE13 - Enabled items numbered in fixed order
// RULE14 - At most four zones enabled
// RULE15 - Zone input high on, low off
// RULE16 - Mode codes 001,010,011,101,111 only; code passes every mode_i code through, 000 and 100 too
// RULE17 - Shots 1 to 100 defined; code passes any shot_i value 0 to 127 through
// RULE18 - Status 4 high after rejected setpoint
// RULE19 - Zone input without item ignored
module gszio_top
    import gszio_pkg::*;
(
    input  wire logic        clk,
    input  wire logic        rst_n,
    input  wire logic [7:0]  avs_address,
    input  wire logic        avs_read,
    input  wire logic        avs_write,
    input  wire logic [31:0] avs_writedata,
    output logic      [31:0] avs_readdata,
    output logic             avs_waitrequest,
    output logic             irq,
    input  wire logic [2:0]  mode_i,
    input  wire logic [6:0]  shot_i,
    input  wire logic        valve_lock_i,
    input  wire logic        valve_open_i,
    input  wire logic        pump_parked_i,
    input  wire logic        setp_strobe_i,
    input  wire logic [11:0] ain1_i,
    input  wire logic [23:0] p_blue_i,
    input  wire logic [23:0] p_red_i,
    input  wire logic [23:0] flow_i,
    input  wire logic [7:0]  item_en_i,
    input  wire logic [3:0]  zone_in_i,
    output logic      [2:0]  mode_o,
    output logic      [6:0]  shot_o,
    output logic             reject_o,
    output logic      [11:0] aout1_o,
    output logic      [11:0] aout2_o,
    output logic      [11:0] aout3_o,
    output logic      [11:0] aout4_o,
    output logic      [23:0] setp_o,
    output logic      [7:0]  item_on_o
);
    // ********************************
    // Registers and state
    // ********************************
    logic [4:0]  ctrl_q;
    logic [23:0] mwp_q, vol_q, wgt_q;
    logic [2:0]  ist_q, ien_q;
    logic        ack_q;
    logic [31:0] rdata_q;
    logic [2:0]  mode_q;
    logic [6:0]  shot_q;
    logic        reject_q, strobe_q, sp_pend_q;
    logic [11:0] ain_q;
    logic [11:0] aout_q [3];
    logic [23:0] setp_q;
    gszio_div_t  dst_q;
    logic [1:0]  ch_q;
    logic [5:0]  step_q;
    logic [35:0] num_q, quo_q;
    logic [24:0] rem_q;
    logic [23:0] den_q;
    gszio_zone_if zif ();

    // ********************************
    // Bus decode
    // ********************************
    wire req    = avs_read || avs_write;
    wire wr_go  = avs_write && ack_q;
    wire rd_sel_ctrl = avs_address == OFS_CTRL;
    wire [31:0] rd_mux =
        rd_sel_ctrl                   ? {27'h0, ctrl_q} :
        (avs_address == OFS_MWP)      ? {8'h00, mwp_q} :
        (avs_address == OFS_VOLSZ)    ? {8'h00, vol_q} :
        (avs_address == OFS_WGTSZ)    ? {8'h00, wgt_q} :
        (avs_address == OFS_SETP)     ? {8'h00, setp_q} :
        (avs_address == OFS_PINS)     ? {21'h0, reject_q, shot_q, mode_q} :
        (avs_address == OFS_IRQ_ST)   ? {29'h0, ist_q} :
        (avs_address == OFS_IRQ_EN)   ? {29'h0, ien_q} :
        (avs_address == OFS_ZONE)     ? {21'h0, zif.zone_cnt, item_on_o} :
                                        32'h0;
    // One wait state: read data is latched, then presented
    assign avs_waitrequest = req && !ack_q;
    assign avs_readdata    = rdata_q;

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            ack_q   <= 1'b0;
            rdata_q <= 32'h0;
        end else begin
            ack_q   <= req && !ack_q;
            rdata_q <= rd_mux;
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            ctrl_q <= CTRL_RST;
            mwp_q  <= SIZE_RST;
            vol_q  <= SIZE_RST;
            wgt_q  <= SIZE_RST;
            ien_q  <= IRQ_RST;
        end else if (wr_go) begin
            if (avs_address == OFS_CTRL) begin
                ctrl_q <= avs_writedata[4:0];
            end else if (avs_address == OFS_MWP) begin
                mwp_q <= avs_writedata[23:0];
            end else if (avs_address == OFS_VOLSZ) begin
                vol_q <= avs_writedata[23:0];
            end else if (avs_address == OFS_WGTSZ) begin
                wgt_q <= avs_writedata[23:0];
            end else if (avs_address == OFS_IRQ_EN) begin
                ien_q <= avs_writedata[2:0];
            end
        end
    end

    // ********************************
    // Status outputs
    // ********************************
    wire [1:0] unit  = ctrl_q[CTRL_UNIT_LSB +: 2];
    wire [1:0] spm   = ctrl_q[CTRL_SPM_LSB +: 2];
    wire       a3f   = ctrl_q[CTRL_A3F_BIT];
    wire       in_stby = mode_i == MODE_STBY;
    wire       in_shot = mode_i == MODE_SHOT;
    // Status 24 is the shot LSB, so the standby flags sit in the low bits
    wire [6:0] stby_bits = {4'h0, valve_lock_i, valve_open_i, pump_parked_i}; // RULE3 RULE4 RULE5
    wire [6:0] shot_d = in_shot ? shot_i : (in_stby ? stby_bits : 7'h00); // RULE2

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            mode_q <= 3'h0;
            shot_q <= 7'h00;
        end else begin
            mode_q <= mode_i; // RULE1 RULE16
            shot_q <= shot_d; // RULE17
        end
    end

    // ********************************
    // Setpoint strobe
    // ********************************
    // Strobe sampled on its rising edge; settle time is the controller's job
    wire strobe_rise = setp_strobe_i && !strobe_q; // RULE8
    wire sp_bad      = strobe_rise && (mode_i != MODE_OPER);
    wire sp_take     = strobe_rise && (mode_i == MODE_OPER);
    wire div_fin     = dst_q == DS_DONE;
    wire sp_done     = div_fin && ch_q == 2'h3;

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            strobe_q  <= 1'b0;
            sp_pend_q <= 1'b0;
            reject_q  <= 1'b0;
            ain_q     <= 12'h000;
        end else begin
            strobe_q <= setp_strobe_i;
            if (sp_bad) begin
                reject_q <= 1'b1; // RULE18 RULE9
            end else if (sp_take) begin
                reject_q  <= 1'b0;
                ain_q     <= ain1_i; // RULE6
                sp_pend_q <= 1'b1;
            end else if (sp_done) begin
                sp_pend_q <= 1'b0;
            end
        end
    end

    // ********************************
    // Full scales
    // ********************************
    wire [23:0] marg = (unit == UNIT_PSI) ? MARG_PSI :
                       (unit == UNIT_BAR) ? MARG_BAR : MARG_MPA; // RULE11
    wire [23:0] fs_p = 24'(mwp_q + marg); // RULE10
    wire [23:0] fs_f = (spm == SPM_WGT) ? wgt_q : vol_q; // RULE12
    wire [23:0] fs_s = (spm == SPM_PRES) ? mwp_q : fs_f; // RULE7

    // ********************************
    // Shared serial divider
    // ********************************
    // One divider for all channels: slow refresh traded for area
    wire [23:0] src3 = a3f ? flow_i : p_blue_i; // RULE12
    wire [23:0] psrc = (ch_q == 2'h0) ? p_blue_i :
                       (ch_q == 2'h1) ? p_red_i : src3;
    wire [35:0] num_a = 36'(psrc) * 36'(DAC_FS);
    wire [35:0] num_s = 36'(ain_q) * 36'(fs_s); // RULE7
    wire [35:0] num_l = (ch_q == 2'h3) ? num_s : num_a;
    wire [23:0] den_l = (ch_q == 2'h3) ? 24'(DAC_FS) :
                        (ch_q == 2'h2 && a3f) ? fs_f : fs_p;
    wire [24:0] rem_sh = {rem_q[23:0], num_q[35]};
    wire        ge     = rem_sh >= {1'b0, den_q};
    // Zero full scale divides to all ones and so saturates
    wire [11:0] q_sat = (quo_q > 36'(DAC_FS)) ? DAC_FS : quo_q[11:0]; // RULE10
    wire [23:0] q_sp  = (quo_q[35:24] != 12'h0) ? 24'hFFFFFF : quo_q[23:0];
    wire [1:0]  ch_nx = (ch_q == 2'h2 && !sp_pend_q) ? 2'h0 : 2'(ch_q + 2'h1);

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            dst_q  <= DS_LOAD;
            ch_q   <= 2'h0;
            step_q <= 6'h00;
            num_q  <= 36'h0;
            quo_q  <= 36'h0;
            rem_q  <= 25'h0;
            den_q  <= 24'h0;
        end else begin
            case (dst_q)
                DS_LOAD: begin
                    num_q  <= num_l;
                    den_q  <= den_l;
                    rem_q  <= 25'h0;
                    step_q <= 6'h00;
                    dst_q  <= DS_RUN;
                end
                DS_RUN: begin
                    rem_q  <= ge ? 25'(rem_sh - {1'b0, den_q}) : rem_sh;
                    num_q  <= {num_q[34:0], 1'b0};
                    quo_q  <= {quo_q[34:0], ge};
                    step_q <= 6'(step_q + 6'h01);
                    if (step_q == 6'(DIV_STEPS - 6'h01)) begin
                        dst_q <= DS_DONE;
                    end
                end
                DS_DONE: begin
                    ch_q  <= ch_nx;
                    dst_q <= DS_LOAD;
                end
                default: dst_q <= DS_LOAD;
            endcase
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            aout_q <= '{default: 12'h000};
            setp_q <= 24'h0;
        end else if (div_fin && ch_q != 2'h3) begin
            aout_q[ch_q] <= q_sat; // RULE10 RULE12
        end else if (sp_done) begin
            setp_q <= q_sp; // RULE7
        end
    end

    assign aout1_o  = aout_q[0];
    assign aout2_o  = aout_q[1];
    assign aout3_o  = aout_q[2];
    assign aout4_o  = 12'h000; // RULE6
    assign mode_o   = mode_q;
    assign shot_o   = shot_q;
    assign reject_o = reject_q;
    assign setp_o   = setp_q;

    // ********************************
    // Interrupts
    // ********************************
    wire [2:0] ev;
    assign ev[IRQ_ACC]  = sp_done;
    assign ev[IRQ_REJ]  = sp_bad;
    assign ev[IRQ_MODE] = mode_q != mode_i;
    wire [2:0] clr = (wr_go && avs_address == OFS_IRQ_CLR) ? avs_writedata[2:0] : 3'h0;

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            ist_q <= IRQ_RST;
        end else begin
            ist_q <= (ist_q & ~clr) | ev; // set wins over clear
        end
    end

    assign irq = |(ist_q & ien_q);

    // ********************************
    // Zones
    // ********************************
    assign zif.item_en = item_en_i;
    assign zif.zone_in = zone_in_i;
    assign item_on_o   = zif.item_on; // RULE15

    gszio_zone_map u_zone (
        .zif (zif.mapper)
    );

    // ********************************
    // Assertions
    // ********************************
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);

    property p_mode_out;
        !$past(!rst_n) |-> mode_o == $past(mode_i);
    endproperty
    a_mode_out: assert property (p_mode_out) else $error("mode out mismatch"); // RULE1

    property p_shot_out;
        $past(mode_i) == MODE_SHOT && !$past(!rst_n) |-> shot_o == $past(shot_i);
    endproperty
    a_shot_out: assert property (p_shot_out) else $error("shot out mismatch"); // RULE2

    property p_lock_out;
        mode_i == MODE_STBY |=> shot_o[2] == $past(valve_lock_i);
    endproperty
    a_lock_out: assert property (p_lock_out) else $error("lock bit wrong"); // RULE3

    property p_open_out;
        mode_i == MODE_STBY |=> shot_o[1] == $past(valve_open_i);
    endproperty
    a_open_out: assert property (p_open_out) else $error("valve bit wrong"); // RULE4

    property p_park_out;
        mode_i == MODE_STBY |=> shot_o[0] == $past(pump_parked_i);
    endproperty
    a_park_out: assert property (p_park_out) else $error("park bit wrong"); // RULE5

    property p_reject;
        sp_bad |=> reject_o && ist_q[IRQ_REJ];
    endproperty
    a_reject: assert property (p_reject) else $error("reject not flagged"); // RULE18

    property p_accept;
        sp_take |=> !reject_o ##[1:200] sp_done;
    endproperty
    a_accept: assert property (p_accept) else $error("setpoint not converted"); // RULE7

    property p_sat;
        div_fin && ch_q == 2'h1 && quo_q > 36'(DAC_FS) |=> aout2_o == DAC_FS;
    endproperty
    a_sat: assert property (p_sat) else $error("no saturation"); // RULE10

    property p_zone_subset;
        (item_on_o & ~item_en_i) == 8'h00 && $countones(item_on_o) <= 4;
    endproperty
    a_zone_subset: assert property (p_zone_subset) else $error("zone drive bad"); // RULE14

    property p_zone_first;
        item_en_i[0] |-> item_on_o[0] == zone_in_i[0];
    endproperty
    a_zone_first: assert property (p_zone_first) else $error("zone 1 wrong"); // RULE13

    property p_bus_wait;
        req && !ack_q |=> !avs_waitrequest || !req;
    endproperty
    a_bus_wait: assert property (p_bus_wait) else $error("bus stall too long");

    c_reject: cover property (sp_bad);
    c_accept: cover property (sp_done);
    c_irq:    cover property (irq);
    c_four:   cover property (zif.zone_cnt == MAX_ZONES);
endmodule

// [gszio_pkg.sv]
// Package: register map, field layout and codes of the gateway I/O block
package gszio_pkg;
    // ********************************
    // Register byte offsets
    // ********************************
    localparam logic [7:0] OFS_CTRL    = 8'h00;
    localparam logic [7:0] OFS_MWP     = 8'h04;
    localparam logic [7:0] OFS_VOLSZ   = 8'h08;
    localparam logic [7:0] OFS_WGTSZ   = 8'h0C;
    localparam logic [7:0] OFS_SETP    = 8'h10;
    localparam logic [7:0] OFS_PINS    = 8'h14;
    localparam logic [7:0] OFS_IRQ_ST  = 8'h18;
    localparam logic [7:0] OFS_IRQ_CLR = 8'h1C;
    localparam logic [7:0] OFS_IRQ_EN  = 8'h20;
    localparam logic [7:0] OFS_ZONE    = 8'h24;
    // ********************************
    // Fields and reset values
    // ********************************
    localparam int CTRL_UNIT_LSB = 0;
    localparam int CTRL_SPM_LSB  = 2;
    localparam int CTRL_A3F_BIT  = 4;
    localparam logic [4:0]  CTRL_RST = 5'h00;
    localparam logic [23:0] SIZE_RST = 24'h000000;
    localparam logic [2:0]  IRQ_RST  = 3'h0;
    localparam int IRQ_ACC  = 0;
    localparam int IRQ_REJ  = 1;
    localparam int IRQ_MODE = 2;
    // ********************************
    // Units, setpoint modes, pressure margins (x100)
    // ********************************
    localparam logic [1:0]  UNIT_PSI = 2'h0;
    localparam logic [1:0]  UNIT_BAR = 2'h1;
    localparam logic [23:0] MARG_PSI = 24'h00C350;
    localparam logic [23:0] MARG_BAR = 24'h000D7A;
    localparam logic [23:0] MARG_MPA = 24'h000159;
    localparam logic [1:0]  SPM_PRES = 2'h0;
    localparam logic [1:0]  SPM_WGT  = 2'h2;
    // ********************************
    // Operating modes, shots, scaling
    // ********************************
    localparam logic [2:0]  MODE_DIS   = 3'h1;
    localparam logic [2:0]  MODE_STBY  = 3'h2;
    localparam logic [2:0]  MODE_SHOT  = 3'h3;
    localparam logic [2:0]  MODE_OPER  = 3'h5;
    localparam logic [2:0]  MODE_NIGHT = 3'h7;
    localparam logic [6:0]  SHOT_MAX   = 7'h64;
    localparam logic [11:0] DAC_FS     = 12'hFFF;
    localparam logic [5:0]  DIV_STEPS  = 6'h24;
    localparam int NUM_ITEMS = 8;
    localparam logic [2:0]  MAX_ZONES  = 3'h4;
    typedef enum logic [2:0] {
        DS_LOAD = 3'b001,
        DS_RUN  = 3'b010,
        DS_DONE = 3'b100
    } gszio_div_t;
endpackage

// [gszio_zone_if.sv]
// Interface: conditioning item enables, zone inputs and item drive
`timescale 1ns/1ns
interface gszio_zone_if;
    logic [7:0] item_en;
    logic [3:0] zone_in;
    logic [7:0] item_on;
    logic [2:0] zone_cnt;
    modport mapper (input item_en, input zone_in, output item_on, output zone_cnt);
    modport user (output item_en, output zone_in, input item_on, input zone_cnt);
endinterface

// [gszio_zone_map.sv]
// Zone numbering of the eight conditioning items and zone on/off steering
`timescale 1ns/1ns
module gszio_zone_map
    import gszio_pkg::*;
(
    gszio_zone_if.mapper zif
);
    logic [3:0] total;

    // ********************************
    // Per-item zone number
    // ********************************
    genvar k;
    generate
        for (k = 0; k < NUM_ITEMS; k++) begin : g_item
            wire [7:0] below = 8'((9'h001 << k) - 9'h001);
            wire [3:0] rank  = 4'($countones(zif.item_en & below));
            // Fifth and later enabled items get no zone
            wire       has_z = zif.item_en[k] && rank < 4'(MAX_ZONES); // RULE14
            wire [1:0] zidx  = rank[1:0]; // RULE13
            assign zif.item_on[k] = has_z && zif.zone_in[zidx]; // RULE15
        end
    endgenerate

    // Unassigned zone inputs steer no item
    assign total = 4'($countones(zif.item_en)); // RULE19
    assign zif.zone_cnt = (total > 4'(MAX_ZONES)) ? MAX_ZONES : total[2:0]; // RULE14
endmodule

// [gszio_plc_model.sv]
// Behavioural controller model driving analog input 1 and the setpoint strobe
`timescale 1ns/1ns
module gszio_plc_model #(
    parameter int SETTLE = 8,
    parameter int HOLD   = 8
) (
    input  wire logic        clk,
    input  wire logic        go,
    input  wire logic [11:0] target,
    output logic      [11:0] ain1,
    output logic             strobe,
    output logic             done
);
    // ****************************************
    // Settle, strobe, release
    // ****************************************
    // Counts shortened; the real controller waits far longer
    initial begin
        ain1   = 12'h000;
        strobe = 1'b0;
        done   = 1'b0;
    end
    always begin
        @(posedge clk);
        if (go) begin
            ain1 <= target;
            repeat (SETTLE) @(posedge clk);
            strobe <= 1'b1;
            repeat (HOLD) @(posedge clk);
            strobe <= 1'b0;
            done   <= 1'b1;
            @(posedge clk);
            done   <= 1'b0;
        end
    end
endmodule

// [gszio_top_tb_top.sv]
// Self-checking bench of the gateway status, setpoint, analog and zone block
`timescale 1ns/1ns
module gszio_top_tb_top;
    import gszio_pkg::*;
    localparam logic [23:0] MWP = 24'h030D40;
    localparam logic [23:0] VOL = 24'h006D60;
    localparam logic [23:0] WGT = 24'h0080E8;
    localparam logic [2:0]  MTAB [7] = '{3'h1, 3'h2, 3'h3, 3'h5, 3'h7, 3'h0, 3'h4};
    localparam logic [6:0]  STAB [5] = '{7'h00, 7'h01, 7'h64, 7'h65, 7'h7F};
    localparam logic [23:0] MARG [3] = '{MARG_PSI, MARG_BAR, MARG_MPA};
    logic        clk = 1'b0;
    logic        rst_n = 1'b0;
    logic [7:0]  avs_address = 8'h00;
    logic        avs_read = 1'b0;
    logic        avs_write = 1'b0;
    logic [31:0] avs_writedata = 32'h0;
    logic [31:0] avs_readdata;
    logic        avs_waitrequest;
    logic        irq;
    logic [2:0]  mode_i = 3'h0;
    logic [6:0]  shot_i = 7'h00;
    logic        lock_i = 1'b0;
    logic        open_i = 1'b0;
    logic        park_i = 1'b0;
    logic        strobe;
    logic [11:0] ain1;
    logic [23:0] p_blue_i = 24'h0;
    logic [23:0] p_red_i = 24'h0;
    logic [23:0] flow_i = 24'h0;
    logic [7:0]  item_en_i = 8'h00;
    logic [3:0]  zone_in_i = 4'h0;
    logic [2:0]  mode_o;
    logic [6:0]  shot_o;
    logic        reject_o;
    logic [11:0] aout1_o, aout2_o, aout3_o, aout4_o;
    logic [23:0] setp_o;
    logic [7:0]  item_on_o;
    logic        go = 1'b0;
    logic [11:0] target = 12'h000;
    logic        done;
    logic [31:0] lfsr = 32'h3839;
    logic [31:0] rd;
    int          errors = 0;
    int          num_checks = 0;
    always #20 clk = ~clk;
    gszio_top i_dut (.clk(clk), .rst_n(rst_n), .avs_address(avs_address),
        .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
        .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .irq(irq),
        .mode_i(mode_i), .shot_i(shot_i), .valve_lock_i(lock_i), .valve_open_i(open_i),
        .pump_parked_i(park_i), .setp_strobe_i(strobe), .ain1_i(ain1),
        .p_blue_i(p_blue_i), .p_red_i(p_red_i), .flow_i(flow_i), .item_en_i(item_en_i),
        .zone_in_i(zone_in_i), .mode_o(mode_o), .shot_o(shot_o), .reject_o(reject_o),
        .aout1_o(aout1_o), .aout2_o(aout2_o), .aout3_o(aout3_o), .aout4_o(aout4_o),
        .setp_o(setp_o), .item_on_o(item_on_o));
    gszio_plc_model i_plc (.clk(clk), .go(go), .target(target), .ain1(ain1),
        .strobe(strobe), .done(done));
    // ****************************************
    // Expectations and helpers
    // ****************************************
    function automatic logic [31:0] rnd();
        lfsr = {lfsr[30:0], lfsr[31] ^ lfsr[21] ^ lfsr[1] ^ lfsr[0]};
        return lfsr;
    endfunction
    // Zero full scale saturates rather than divides
    function automatic logic [11:0] code(input logic [23:0] p, input logic [23:0] fs);
        longint q;
        q = (fs == 24'h0) ? 4096 : (longint'(p) * 4095) / fs;
        return (q > 4095) ? DAC_FS : q[11:0];
    endfunction
    function automatic logic [6:0] sexp(input logic [2:0] m, input logic [6:0] s,
                                        input logic l, input logic o, input logic p);
        if (m === MODE_SHOT) return s;
        if (m === MODE_STBY) return {4'h0, l, o, p};
        return 7'h00;
    endfunction
    function automatic logic [7:0] zexp(input logic [7:0] en, input logic [3:0] z);
        int r;
        logic [7:0] v;
        r = 0;
        v = 8'h00;
        for (int k = 0; k < NUM_ITEMS; k++) begin
            if (en[k]) begin
                if (r < 4) v[k] = z[r];
                r++;
            end
        end
        return v;
    endfunction
    task automatic conclude();
        $display("checks %0d mismatches %0d", num_checks, errors);
        if (errors == 0 && num_checks > 0) $display("ALL CHECKS OK");
        else $display("CHECKS NOT OK");
        $finish;
    endtask
    task automatic bail(input string m);
        errors++;
        $display("MISMATCH %0t timeout %s", $time, m);
        conclude();
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string m);
        num_checks++;
        if (got !== exp) begin
            errors++;
            $display("MISMATCH %0t %s got %h exp %h", $time, m, got, exp);
        end
    endtask
    // Request held until the rising edge that sees waitrequest low
    task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d);
        int n;
        n = 0;
        @(posedge clk);
        avs_address   <= a;
        avs_write     <= wr;
        avs_read      <= ~wr;
        avs_writedata <= d;
        @(posedge clk);
        while (avs_waitrequest !== 1'b0) begin
            n++;
            if (n > 50) bail("bus");
            @(posedge clk);
        end
        rd = avs_readdata;
        avs_read  <= 1'b0;
        avs_write <= 1'b0;
    endtask
    task automatic rdchk(input logic [7:0] a, input logic [31:0] exp, input string m);
        bus(1'b0, a, 32'h0);
        chk(rd, exp, m);
    endtask
    task automatic settle(input int n);
        repeat (n) @(posedge clk);
        @(negedge clk);
    endtask
    task automatic sp(input logic [11:0] a);
        int n;
        @(posedge clk);
        target <= a;
        go     <= 1'b1;
        @(posedge clk);
        go <= 1'b0;
        n = 0;
        while (done !== 1'b1) begin
            @(negedge clk);
            n++;
            if (n > 100) bail("strobe");
        end
    endtask
    // ****************************************
    // Main sequence
    // ****************************************
    initial begin
        logic [23:0] fs;
        logic [11:0] a;
        logic [6:0]  sx;
        int n;
        repeat (20) @(posedge clk);
        rst_n <= 1'b1;
        rdchk(OFS_CTRL, 32'h0, "ctrl reset");
        rdchk(OFS_IRQ_EN, 32'h0, "irq enable reset");
        bus(1'b1, 8'h40, 32'hFFFFFFFF);
        rdchk(8'h40, 32'h0, "unmapped");
        chk(irq, 1'b0, "irq reset");
        $display("test reset done");
        for (int i = 0; i < 18; i++) begin
            @(posedge clk);
            mode_i <= MTAB[i % 7];
            shot_i <= (i < 5) ? STAB[i] : 7'(rnd());
            {lock_i, open_i, park_i} <= 3'(rnd());
            settle(2);
            sx = sexp(mode_i, shot_i, lock_i, open_i, park_i);
            chk(mode_o, mode_i, "mode");
            chk(shot_o, sx, "shot");
            rdchk(OFS_PINS, {22'h0, sx, mode_i}, "pins");
        end
        $display("test status done");
        @(posedge clk);
        mode_i <= MODE_STBY;
        settle(2);
        rdchk(OFS_IRQ_ST, 32'h4, "mode event");
        bus(1'b1, OFS_IRQ_CLR, 32'h7);
        bus(1'b1, OFS_IRQ_EN, 32'h2);
        sp(12'(rnd()));
        chk(reject_o, 1'b1, "reject");
        chk(irq, 1'b1, "reject irq");
        bus(1'b1, OFS_IRQ_CLR, 32'h2);
        settle(1);
        chk(irq, 1'b0, "irq cleared");
        chk(reject_o, 1'b1, "reject stands");
        $display("test reject done");
        @(posedge clk);
        mode_i <= MODE_OPER;
        bus(1'b1, OFS_MWP, 32'(MWP));
        bus(1'b1, OFS_VOLSZ, 32'(VOL));
        bus(1'b1, OFS_WGTSZ, 32'(WGT));
        bus(1'b1, OFS_IRQ_EN, 32'h1);
        for (int m = 0; m < 3; m++) begin
            fs = (m == 0) ? MWP : (m == 1) ? VOL : WGT;
            a = (m == 0) ? 12'hFFF : (m == 1) ? 12'h000 : 12'(rnd());
            bus(1'b1, OFS_CTRL, 32'(m << CTRL_SPM_LSB));
            bus(1'b1, OFS_IRQ_CLR, 32'h7);
            sp(a);
            chk(reject_o, 1'b0, "accept");
            n = 0;
            while (irq !== 1'b1) begin
                @(negedge clk);
                n++;
                if (n > 200) bail("setpoint");
            end
            chk(setp_o, 24'((longint'(a) * fs) / 4095), "setpoint");
            rdchk(OFS_SETP, 32'((longint'(a) * fs) / 4095), "setpoint reg");
        end
        $display("test setpoint done");
        bus(1'b1, OFS_WGTSZ, 32'(VOL));
        for (int u = 0; u < 3; u++) begin
            fs = MWP + MARG[u];
            bus(1'b1, OFS_CTRL, 32'(u));
            @(posedge clk);
            p_blue_i <= 24'(rnd() % fs);
            p_red_i  <= fs + 24'(rnd() % 4096);
            flow_i   <= 24'(rnd() % 30000);
            // Rotation of the three output channels fits well inside this wait
            settle(200);
            chk(aout1_o, code(p_blue_i, fs), "blue");
            chk(aout2_o, code(p_red_i, fs), "red saturates");
            chk(aout3_o, code(p_blue_i, fs), "out3 pressure");
            chk(aout4_o, 12'h000, "out4");
            bus(1'b1, OFS_CTRL, 32'(u) | 32'h14);
            settle(200);
            chk(aout3_o, code(flow_i, VOL), "out3 flow");
        end
        $display("test analog done");
        for (int i = 0; i < 20; i++) begin
            @(posedge clk);
            item_en_i <= (i == 0) ? 8'hFF : (i == 1) ? 8'h69 : 8'(rnd());
            zone_in_i <= (i < 2) ? 4'hF : 4'(rnd());
            settle(1);
            chk(item_on_o, zexp(item_en_i, zone_in_i), "zones");
        end
        $display("test zones done");
        conclude();
    end
endmodule
